// ---- shared/misc_io_pkg.sv ----
package misc_io_pkg;
  // Chip reset must be seen low on this many consecutive clocks.
  localparam int unsigned RESET_HOLD_CYCLES = 2;
  // Bus clock divisor encodings (system clock /2, /3, /5, /6).
  localparam logic [1:0] DIV_SEL_2 = 2'h0;
  localparam logic [1:0] DIV_SEL_3 = 2'h1;
  localparam logic [1:0] DIV_SEL_5 = 2'h2;
  localparam logic [1:0] DIV_SEL_6 = 2'h3;
  localparam logic [2:0] DIV_VAL_2 = 3'h2;
  localparam logic [2:0] DIV_VAL_3 = 3'h3;
  localparam logic [2:0] DIV_VAL_5 = 3'h5;
  localparam logic [2:0] DIV_VAL_6 = 3'h6;
  // Tone: slow-clock ticks per half period of the piezo square wave (about 1 kHz).
  localparam logic [4:0] TONE_HALF_TICKS = 5'h10;
  // Beep cadence in half-tone periods: on time and off time.
  localparam logic [9:0] BEEP_ON_HALVES  = 10'h0c8;
  localparam logic [9:0] BEEP_OFF_HALVES = 10'h0c8;
  // Output-pin mode encodings per pin: 0 = general purpose level, 1 = strobe/select.
  localparam logic MODE_GPO = 1'b0;
  localparam logic MODE_FN  = 1'b1;
endpackage

// ---- design/sync_edge.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser with a rising-edge pulse taken from the second stage.
module sync_edge
  import misc_io_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // Data.
  input  wire logic d_i,
  input  wire logic rst_val_i,
  output logic      q_o,
  output logic      rise_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } state_s;
  state_s st;
  state_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o    = st.s2;
  assign rise_o = st.s2 & ~st.s3;
  // rst_val_i is unused by design; kept zero-width-safe for uniform instances.
  logic unused;
  assign unused = rst_val_i;
endmodule

// ---- design/misc_io_power_control.sv ----
`timescale 1ns/1ps
// How it works
// R01: Chip reset low for two synchronised clocks returns all state to defaults.
// R02: Battery-low held low makes the tone output beep.
// R03: Four general inputs are latched into an input register for the host.
// R04: Each latch pulse output is either a level output or a strobe.
// R05: Third latch pulse output may instead act as automatic power control.
// R06: Each select output is either a level output or a chip select.
// R07: Tone and watchdog timing come from the slow oscillator clock only.
// R08: Chain-active output follows this device's selection one clock later, and is held low during soft reset.
// R09: Identity-query output goes low while a product-id request is active.
// R10: Supply detect low disables every output driver; high enables them.
// R11: Test input exposes buried counter chains; normally held low.
// R12: Bus clock output is the system clock divided by the programmed divisor.
// R13: After reset the device is in pass-through, chain-active low.
// R14: Chip reset and battery-low are synchronised before use.
module misc_io_power_control
  import misc_io_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // Pins from the peripheral system.
  input  wire logic       chip_reset_n_i,
  input  wire logic       battery_low_n_i,
  input  wire logic [3:0] gp_in_i,
  input  wire logic       slow_osc_in_i,
  input  wire logic       supply_detect_i,
  input  wire logic       test_i,
  // Control from the protocol and register logic.
  input  wire logic       chain_selected_i,
  input  wire logic       id_query_i,
  input  wire logic [2:0] pulse_mode_i,
  input  wire logic [2:0] pulse_level_i,
  input  wire logic [2:0] pulse_strobe_i,
  input  wire logic       auto_power_en_i,
  input  wire logic       power_down_req_i,
  input  wire logic [3:0] select_mode_i,
  input  wire logic [3:0] select_level_i,
  input  wire logic [3:0] select_strobe_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       watchdog_beep_i,
  // Status to the register logic.
  output logic [3:0]      input_reg_o,
  output logic            soft_reset_o,
  output logic [15:0]     test_count_o,
  // Pins to the peripheral system.
  output logic            tone_o,
  output logic            tone_oe_o,
  output logic [2:0]      latch_pulse_outs_n_o,
  output logic [2:0]      latch_pulse_oe_o,
  output logic [3:0]      select_outs_n_o,
  output logic [3:0]      select_oe_o,
  output logic            chain_active_out_o,
  output logic            ident_query_out_n_o,
  output logic            bus_clock_o,
  output logic            misc_oe_o
);
  logic rst_q;
  logic bat_q;
  logic osc_rise;

  // Chip reset, battery-low and the slow oscillator pass a two-flop stage before any logic sees them.
  sync_edge u_sync_rst (  // [R14]
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (~chip_reset_n_i),
    .rst_val_i (1'b0),
    .q_o       (rst_q),
    .rise_o    ()
  );
  sync_edge u_sync_bat (  // [R14]
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (~battery_low_n_i),
    .rst_val_i (1'b0),
    .q_o       (bat_q),
    .rise_o    ()
  );
  // The slow oscillator is sampled; its rising edge is the tone time base.
  sync_edge u_sync_osc (  // [R07]
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       (slow_osc_in_i),
    .rst_val_i (1'b0),
    .q_o       (),
    .rise_o    (osc_rise)
  );

  typedef enum logic [1:0] {
    BEEP_IDLE = 2'b00,
    BEEP_ON   = 2'b01,
    BEEP_OFF  = 2'b11
  } beep_e;

  typedef struct packed {
    logic        rst_seen;
    logic        soft_reset;
    logic [3:0]  input_reg;
    beep_e       beep;
    logic [4:0]  tone_tick;
    logic        tone_wave;
    logic [9:0]  halves;
    logic        tone;
    logic [2:0]  pulse_n;
    logic [3:0]  select_n;
    logic        chain_active;
    logic        ident_n;
    logic [2:0]  div_cnt;
    logic        bus_clock;
    logic        oe;
    logic [15:0] test_count;
  } state_s;

  state_s st;
  state_s next_st;

  function automatic logic [2:0] div_value(input logic [1:0] sel);
    case (sel)
      DIV_SEL_2: div_value = DIV_VAL_2;
      DIV_SEL_3: div_value = DIV_VAL_3;
      DIV_SEL_5: div_value = DIV_VAL_5;
      DIV_SEL_6: div_value = DIV_VAL_6;
      default:   div_value = DIV_VAL_2;
    endcase
  endfunction

  always_comb begin
    logic [2:0] div;
    logic       beeping;
    div     = div_value(div_sel_i);
    beeping = bat_q | watchdog_beep_i;
    next_st = st;

    next_st.rst_seen   = rst_q;
    // Two consecutive low samples after the synchroniser make a reset.
    next_st.soft_reset = rst_q & st.rst_seen;  // [R01]

    next_st.input_reg = gp_in_i;  // [R03]

    // Tone square wave advances only on slow-oscillator ticks.
    if (osc_rise) begin  // [R07]
      if (st.tone_tick == TONE_HALF_TICKS - 5'h01) begin
        next_st.tone_tick = '0;
        next_st.tone_wave = ~st.tone_wave;
        next_st.halves    = st.halves + 10'h001;
      end else begin
        next_st.tone_tick = st.tone_tick + 5'h01;
      end
    end

    case (st.beep)
      BEEP_IDLE: begin
        next_st.halves = '0;
        if (beeping) begin  // [R02]
          next_st.beep = BEEP_ON;
        end
      end
      BEEP_ON: begin
        if (st.halves >= BEEP_ON_HALVES) begin
          next_st.beep   = BEEP_OFF;
          next_st.halves = '0;
        end
      end
      BEEP_OFF: begin
        if (st.halves >= BEEP_OFF_HALVES) begin
          next_st.beep   = beeping ? BEEP_ON : BEEP_IDLE;
          next_st.halves = '0;
        end
      end
      default: next_st.beep = BEEP_IDLE;
    endcase
    next_st.tone = (st.beep == BEEP_ON) & st.tone_wave;  // [R02]

    for (int i = 0; i < 3; i++) begin
      next_st.pulse_n[i] = (pulse_mode_i[i] == MODE_FN) ? ~pulse_strobe_i[i]
                                                        : ~pulse_level_i[i];  // [R04]
    end
    // Auto-power use of the third pulse pin takes precedence over its mode.
    if (auto_power_en_i) begin  // [R05]
      next_st.pulse_n[2] = ~power_down_req_i;
    end
    for (int i = 0; i < 4; i++) begin
      next_st.select_n[i] = (select_mode_i[i] == MODE_FN) ? ~select_strobe_i[i]
                                                          : ~select_level_i[i];  // [R06]
    end

    next_st.chain_active = chain_selected_i;  // [R08]
    next_st.ident_n      = ~id_query_i;  // [R09]

    // Divider: high for the first div >> 1 clocks of each period (half, rounded down), low for the rest.
    if (st.div_cnt >= div - 3'h1) begin  // [R12]
      next_st.div_cnt = '0;
    end else begin
      next_st.div_cnt = st.div_cnt + 3'h1;
    end
    next_st.bus_clock = (next_st.div_cnt < (div >> 1));  // [R12]

    next_st.oe = supply_detect_i;  // [R10]

    // Buried system-clock counter only runs and shows in test mode.
    next_st.test_count = test_i ? st.test_count + 16'h0001 : 16'h0000;  // [R11]

    if (st.soft_reset) begin  // [R01]
      next_st = '0;
      next_st.pulse_n  = '1;
      next_st.select_n = '1;
      next_st.ident_n  = 1'b1;
      next_st.oe       = supply_detect_i;
      next_st.rst_seen   = rst_q;
      next_st.soft_reset = rst_q & st.rst_seen;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st          <= '0;
      st.pulse_n  <= '1;
      st.select_n <= '1;
      st.ident_n  <= 1'b1;
      st.chain_active <= 1'b0;  // [R13]
    end else begin
      st <= next_st;
    end
  end

  assign input_reg_o          = st.input_reg;
  assign soft_reset_o         = st.soft_reset;
  assign test_count_o         = st.test_count;
  assign tone_o               = st.tone;
  assign latch_pulse_outs_n_o = st.pulse_n;
  assign select_outs_n_o      = st.select_n;
  assign chain_active_out_o   = st.chain_active;
  assign ident_query_out_n_o  = st.ident_n;
  assign bus_clock_o          = st.bus_clock;
  assign tone_oe_o            = st.oe;
  assign latch_pulse_oe_o     = {3{st.oe}};
  assign select_oe_o          = {4{st.oe}};
  assign misc_oe_o            = st.oe;

  sequence s_reset_held;
    rst_q && st.rst_seen;
  endsequence
  property p_reset_two;
    @(posedge clk_i) disable iff (!arst_n_i)
      s_reset_held |=> soft_reset_o;
  endproperty
  a_reset_two: assert property (p_reset_two) else $error("reset not taken");  // [R01]
  property p_reset_clears;
    @(posedge clk_i) disable iff (!arst_n_i)
      soft_reset_o |=> !chain_active_out_o && ident_query_out_n_o && (tone_o == 1'b0);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("state not cleared");  // [R01]

  property p_tone_quiet;
    @(posedge clk_i) disable iff (!arst_n_i)
      (st.beep == BEEP_IDLE) |=> !tone_o;
  endproperty
  a_tone_quiet: assert property (p_tone_quiet) else $error("tone while idle");  // [R02]

  property p_beep_start;
    @(posedge clk_i) disable iff (!arst_n_i)
      (bat_q && st.beep == BEEP_IDLE && !st.soft_reset) |=> st.beep == BEEP_ON;
  endproperty
  a_beep_start: assert property (p_beep_start) else $error("no beep on low battery");  // [R02]

  property p_inputs;
    @(posedge clk_i) disable iff (!arst_n_i)
      !st.soft_reset |=> input_reg_o == $past(gp_in_i);
  endproperty
  a_inputs: assert property (p_inputs) else $error("input register stale");  // [R03]

  property p_auto_power;
    @(posedge clk_i) disable iff (!arst_n_i)
      (auto_power_en_i && !st.soft_reset) |=> latch_pulse_outs_n_o[2] == !$past(power_down_req_i);
  endproperty
  a_auto_power: assert property (p_auto_power) else $error("auto power pin wrong");  // [R05]

  property p_chain;
    @(posedge clk_i) disable iff (!arst_n_i)
      !st.soft_reset |=> chain_active_out_o == $past(chain_selected_i);
  endproperty
  a_chain: assert property (p_chain) else $error("chain active wrong");  // [R08]

  property p_ident;
    @(posedge clk_i) disable iff (!arst_n_i)
      (id_query_i && !st.soft_reset) |=> !ident_query_out_n_o;
  endproperty
  a_ident: assert property (p_ident) else $error("id query not asserted");  // [R09]

  property p_supply;
    @(posedge clk_i) disable iff (!arst_n_i)
      !supply_detect_i |=> (select_oe_o == 4'h0) && !tone_oe_o;
  endproperty
  a_supply: assert property (p_supply) else $error("driver on without supply");  // [R10]
endmodule

// ---- test/periph_model.sv ----
`timescale 1ns/1ps
// Peripheral system: slow crystal, battery monitor and reset button.
module periph_model (
  // Commands from the bench.
  input  wire logic batt_low_i,
  input  wire logic rst_req_i,
  input  wire logic test_req_i,
  // Pins to the device.
  output logic      slow_osc_o,
  output logic      battery_low_n_o,
  output logic      chip_reset_n_o,
  output logic      test_o
);
  // The crystal runs free, so its phase drifts against the system clock.
  initial begin
    slow_osc_o = 1'b0;
    forever #15258.789 slow_osc_o = ~slow_osc_o;
  end
  assign battery_low_n_o = ~batt_low_i;
  assign chip_reset_n_o  = ~rst_req_i;
  // The bench keeps test mode low except in its one short counter check.
  assign test_o          = test_req_i;
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  import misc_io_pkg::*;
  logic        clk_i, arst_n_i, chip_reset_n_i, battery_low_n_i, slow_osc_in_i, test_i;
  logic        supply_detect_i, chain_selected_i, id_query_i, auto_power_en_i;
  logic        power_down_req_i, watchdog_beep_i, soft_reset_o, tone_o, tone_oe_o;
  logic        chain_active_out_o, ident_query_out_n_o, bus_clock_o, misc_oe_o;
  logic        batt_low, rst_req, test_req, prev;
  logic [1:0]  div_sel_i;
  logic [2:0]  pulse_mode_i, pulse_level_i, pulse_strobe_i, latch_pulse_outs_n_o;
  logic [2:0]  latch_pulse_oe_o, exp3;
  logic [3:0]  gp_in_i, select_mode_i, select_level_i, select_strobe_i, input_reg_o;
  logic [3:0]  select_outs_n_o, select_oe_o, exp4;
  logic [15:0] test_count_o;
  logic [2:0]  div_tab[4] = '{DIV_VAL_2, DIV_VAL_3, DIV_VAL_5, DIV_VAL_6};
  int          failures, num_checks, n, r;

  misc_io_power_control i_dut (
    .clk_i                (clk_i),
    .arst_n_i             (arst_n_i),
    .chip_reset_n_i       (chip_reset_n_i),
    .battery_low_n_i      (battery_low_n_i),
    .gp_in_i              (gp_in_i),
    .slow_osc_in_i        (slow_osc_in_i),
    .supply_detect_i      (supply_detect_i),
    .test_i               (test_i),
    .chain_selected_i     (chain_selected_i),
    .id_query_i           (id_query_i),
    .pulse_mode_i         (pulse_mode_i),
    .pulse_level_i        (pulse_level_i),
    .pulse_strobe_i       (pulse_strobe_i),
    .auto_power_en_i      (auto_power_en_i),
    .power_down_req_i     (power_down_req_i),
    .select_mode_i        (select_mode_i),
    .select_level_i       (select_level_i),
    .select_strobe_i      (select_strobe_i),
    .div_sel_i            (div_sel_i),
    .watchdog_beep_i      (watchdog_beep_i),
    .input_reg_o          (input_reg_o),
    .soft_reset_o         (soft_reset_o),
    .test_count_o         (test_count_o),
    .tone_o               (tone_o),
    .tone_oe_o            (tone_oe_o),
    .latch_pulse_outs_n_o (latch_pulse_outs_n_o),
    .latch_pulse_oe_o     (latch_pulse_oe_o),
    .select_outs_n_o      (select_outs_n_o),
    .select_oe_o          (select_oe_o),
    .chain_active_out_o   (chain_active_out_o),
    .ident_query_out_n_o  (ident_query_out_n_o),
    .bus_clock_o          (bus_clock_o),
    .misc_oe_o            (misc_oe_o)
  );
  periph_model i_periph (
    .batt_low_i      (batt_low),
    .rst_req_i       (rst_req),
    .test_req_i      (test_req),
    .slow_osc_o      (slow_osc_in_i),
    .battery_low_n_o (battery_low_n_i),
    .chip_reset_n_o  (chip_reset_n_i),
    .test_o          (test_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A stuck tone would hang the run, so the wait is capped.
  task automatic wait_tone(output int k);
    logic t0;
    t0 = tone_o;
    k = 0;
    while (tone_o === t0 && k < 6000) begin
      cyc(1);
      k++;
    end
    if (k >= 6000) begin
      failures++;
      complete_run();
    end
  endtask

  initial begin
    {arst_n_i, batt_low, rst_req, test_req, gp_in_i, chain_selected_i, id_query_i} = '0;
    {pulse_mode_i, pulse_level_i, pulse_strobe_i, auto_power_en_i, power_down_req_i} = '0;
    {select_mode_i, select_level_i, select_strobe_i, div_sel_i, watchdog_beep_i} = '0;
    supply_detect_i = 1'b1;
    failures = 0;
    num_checks = 0;
    cyc(12);
    chk("chain_reset", chain_active_out_o, 0);
    chk("ident_reset", ident_query_out_n_o, 1);
    chk("oe_reset", {latch_pulse_oe_o, select_oe_o}, 0);
    arst_n_i = 1'b1;
    cyc(2);
    chk("oe_on", {tone_oe_o, misc_oe_o, latch_pulse_oe_o, select_oe_o}, 16'h1ff);
    supply_detect_i = 1'b0;
    cyc(2);
    chk("oe_off", {tone_oe_o, misc_oe_o, latch_pulse_oe_o, select_oe_o}, 0);
    supply_detect_i = 1'b1;
    $display("test supply done");
    for (int v = 1; v < 16; v += 5) begin
      gp_in_i = 4'(v);
      cyc(1);
      chk("input_reg", input_reg_o, gp_in_i);
    end
    {pulse_level_i, pulse_strobe_i, select_level_i, select_strobe_i} = 14'h2e96;
    for (int m = 0; m < 8; m++) begin
      pulse_mode_i = 3'(m);
      select_mode_i = {m[0], 3'(m)};
      exp3 = ~((pulse_mode_i & pulse_strobe_i) | (~pulse_mode_i & pulse_level_i));
      exp4 = ~((select_mode_i & select_strobe_i) | (~select_mode_i & select_level_i));
      cyc(1);
      chk("latch_pulse", latch_pulse_outs_n_o, exp3);
      chk("select", select_outs_n_o, exp4);
    end
    {pulse_mode_i, pulse_level_i, auto_power_en_i} = 7'h01;
    for (int p = 0; p < 2; p++) begin
      power_down_req_i = p[0];
      cyc(1);
      chk("auto_power", latch_pulse_outs_n_o, {!p[0], 2'b11});
    end
    auto_power_en_i = 1'b0;
    for (int c = 0; c < 2; c++) begin
      chain_selected_i = !c[0];
      id_query_i = !c[0];
      cyc(1);
      chk("chain_active", chain_active_out_o, !c[0]);
      chk("ident", ident_query_out_n_o, c[0]);
    end
    $display("test pins done");
    for (int d = 0; d < 4; d++) begin
      div_sel_i = 2'(d);
      cyc(12);
      r = 0;
      prev = bus_clock_o;
      repeat (60) begin
        cyc(1);
        if (prev === 1'b0 && bus_clock_o === 1'b1)
          r++;
        prev = bus_clock_o;
      end
      chk("bus_clock_rises", 16'(r), 16'(60 / div_tab[d]));
    end
    chain_selected_i = 1'b1;
    rst_req = 1'b1;
    cyc(1);
    rst_req = 1'b0;
    repeat (6) begin
      cyc(1);
      chk("glitch", {soft_reset_o, chain_active_out_o}, 16'h1);
    end
    rst_req = 1'b1;
    n = 0;
    while (soft_reset_o !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk("reset_delay", 16'(n), 16'(RESET_HOLD_CYCLES + 2));
    cyc(1);
    chk("reset_clears", chain_active_out_o, 0);
    cyc(2);
    chk("reset_holds", {soft_reset_o, chain_active_out_o}, 16'h2);
    rst_req = 1'b0;
    cyc(8);
    chk("reset_done", soft_reset_o, 0);
    chk("chain_back", chain_active_out_o, 1);
    chk("test_count", test_count_o, 0);
    test_req = 1'b1;
    cyc(5);
    chk("test_count_run", test_count_o, 5);
    test_req = 1'b0;
    cyc(1);
    chk("test_count_off", test_count_o, 0);
    $display("test reset done");
    chk("tone_quiet", tone_o, 0);
    watchdog_beep_i = 1'b1;
    wait_tone(n);
    chk("watchdog_tone", tone_o, 1);
    watchdog_beep_i = 1'b0;
    batt_low = 1'b1;
    wait_tone(n);
    wait_tone(n);
    chk("tone_half", 16'(n >= 4875 && n <= 4890), 1);
    $display("test tone done");
    complete_run();
  end
endmodule
